// *** hdl/fmsd_regs.vh ***
`ifndef FMSD_REGS_VH
`define FMSD_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define FMSD_ADDR_STATUS1    8'h02
`define FMSD_ADDR_STATUS2    8'h03
`define FMSD_ADDR_DUTY       8'h22

// Reset values
`define FMSD_RST_STATUS      8'h00
`define FMSD_RST_DUTY        8'h55

// Status 1 field positions
`define FMSD_S1_REMOTE_LOW   3
`define FMSD_S1_REMOTE_HIGH  2
`define FMSD_S1_FAN_SLOW     1
`define FMSD_S1_OVERSPEED    0

// Status 2 field positions
`define FMSD_S2_SHUT_INPUT   7
`define FMSD_S2_LOCAL_SHUT   6
`define FMSD_S2_PASSIVE      5
`define FMSD_S2_LOCAL_CRIT   4
`define FMSD_S2_REMOTE_CRIT  3

////////////////////////////////////////////////////////////////////////////
// Duty codes: 0x00 is 0 %, 0xFF is 100 %, one step is 0.392 %
`define FMSD_DUTY_FULL       8'hFF
`define FMSD_DUTY_ZERO       8'h00
// Below 30 % means code 76 or less; 0x4D drives 30.2 %
`define FMSD_DUTY_MIN_SPEED  8'h4D
// Below 7 % means code 17 or less
`define FMSD_DUTY_MIN_DUTY   8'h12
// Counter wraps after 255 steps so that 0xFF stays high
`define FMSD_PWM_LAST        8'hFE

// Shutdown re-arm hysteresis, degrees C at one degree per LSB
`define FMSD_HYST_DEGC       9'h005
// Consecutive slow detections that declare a failed fan
`define FMSD_FAIL_COUNT      3'h5

////////////////////////////////////////////////////////////////////////////
// Timing
`define FMSD_CLK_MHZ         200
`define FMSD_MON_PERIOD_US   1000
`define FMSD_MON_CYCLES      (`FMSD_MON_PERIOD_US * `FMSD_CLK_MHZ)
`define FMSD_PWM_DIV         31

`endif

// *** hdl/fmsd_sticky.v ***
`timescale 1ns/1ps
`include "fmsd_regs.vh"

// Bank of sticky flags: set wins over a same-cycle clear
module fmsd_sticky #(
  parameter W = 9
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] set,
  input  wire [W-1:0] clr,
  output wire [W-1:0] flag
);

  reg [W-1:0] flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // One flop per flag
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          flag_q[i] <= 1'b0;
        end else if (set[i]) begin
          flag_q[i] <= 1'b1; // Event never lost to a read
        end else if (clr[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flag = flag_q;

endmodule // fmsd_sticky

// *** hdl/fmsd_pwm.v ***
`timescale 1ns/1ps
`include "fmsd_regs.vh"

// Eight-bit PWM, 255 steps per period, output from a flop
module fmsd_pwm (
  input  wire       clock,
  input  wire       rst,
  input  wire       step,
  input  wire [7:0] duty,
  output reg        pwm
);

  reg [7:0] phase;

  ////////////////////////////////////////////////////////////////////////////
  // Phase runs 0..254 so code 0xFF is high all period
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 8'h00;
      pwm   <= 1'b0;
    end else if (step) begin
      if (phase == `FMSD_PWM_LAST) begin
        phase <= 8'h00;
      end else begin
        phase <= phase + 8'h01;
      end
      pwm <= (phase < duty);
    end
  end

endmodule // fmsd_pwm

// *** hdl/fmsd_top.v ***
`timescale 1ns/1ps
`include "fmsd_regs.vh"

module fmsd_top #(
  parameter MON_CYCLES = `FMSD_MON_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  // Register access
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Measurements and limits, signed degrees C
  input  wire [7:0]  remote_temp,
  input  wire [7:0]  remote_low_limit,
  input  wire [7:0]  remote_high_limit,
  input  wire [7:0]  remote_crit_limit,
  input  wire [7:0]  local_temp,
  input  wire [7:0]  local_shutdown_limit,
  input  wire [7:0]  local_crit_limit,
  input  wire [7:0]  control_temp,
  input  wire [7:0]  passive_temp,
  // Tachometer, larger count is slower fan
  input  wire [15:0] tach_count,
  input  wire [15:0] tach_low_limit,
  input  wire [15:0] tach_high_limit,
  input  wire        spinup_active,
  // Control modes and enables
  input  wire        tach_sampling_mode,
  input  wire        mode_sw_speed,
  input  wire        mode_sw_duty,
  input  wire        mode_auto,
  input  wire [7:0]  loop_duty,
  input  wire        overheat_alert_enable,
  input  wire        passive_alert_enable,
  input  wire        fan_range_alert_enable,
  // Shutdown pin, open drain
  input  wire        hot_shutdown_pin_i,
  output reg         hot_shutdown_pin_o,
  output reg         hot_shutdown_pin_oe,
  // Outputs
  output reg         alert_n,
  output reg         overtemp_output_n,
  output reg         fan_fault_n,
  output wire        pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Flag vector layout inside the sticky bank
  localparam F_OVERSPEED   = 0;
  localparam F_FAN_SLOW    = 1;
  localparam F_REMOTE_HIGH = 2;
  localparam F_REMOTE_LOW  = 3;
  localparam F_REMOTE_CRIT = 4;
  localparam F_LOCAL_CRIT  = 5;
  localparam F_PASSIVE     = 6;
  localparam F_LOCAL_SHUT  = 7;
  localparam F_SHUT_INPUT  = 8;

  localparam PWM_DIV = `FMSD_PWM_DIV;

  reg  [31:0] mon_cnt;
  reg         mon_tick;
  reg  [7:0]  pwm_div_cnt;
  reg         pwm_step;
  reg         spinup_prev;
  reg  [2:0]  slow_run;
  reg         overspeed_armed;
  reg         shut_armed;
  reg  [7:0]  duty_setting;
  reg  [8:0]  flag_set;
  reg  [8:0]  flag_clr;
  reg  [7:0]  next_rdata;
  reg  [7:0]  duty_calc;
  reg  [7:0]  duty_drive;
  reg         clamp_active;
  wire [8:0]  flags;

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring-cycle divider, one-cycle enable
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mon_cnt  <= 32'h0000_0000;
      mon_tick <= 1'b0;
    end else if (mon_cnt == MON_CYCLES - 1) begin
      mon_cnt  <= 32'h0000_0000;
      mon_tick <= 1'b1;
    end else begin
      mon_cnt  <= mon_cnt + 32'h0000_0001;
      mon_tick <= 1'b0;
    end
  end

  // PWM step divider
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_div_cnt <= 8'h00;
      pwm_step    <= 1'b0;
    end else if (pwm_div_cnt == PWM_DIV[7:0] - 8'h01) begin
      pwm_div_cnt <= 8'h00;
      pwm_step    <= 1'b1;
    end else begin
      pwm_div_cnt <= pwm_div_cnt + 8'h01;
      pwm_step    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparisons, temperatures are two's complement
  wire rt_low   = $signed(remote_temp) <= $signed(remote_low_limit);
  wire rt_high  = $signed(remote_temp) >= $signed(remote_high_limit);
  wire rt_crit  = $signed(remote_temp) >= $signed(remote_crit_limit);
  wire lt_crit  = $signed(local_temp)  >= $signed(local_crit_limit);
  wire lt_shut  = $signed(local_temp)  >  $signed(local_shutdown_limit);
  wire ct_psv   = $signed(control_temp) <= $signed(passive_temp);
  wire fan_slow = tach_count >= tach_low_limit;
  wire fan_fast = tach_count <= tach_high_limit;

  // Re-arm point: shutdown limit minus hysteresis, one bit wider
  wire signed [8:0] shut_rearm = $signed({local_shutdown_limit[7],
                                          local_shutdown_limit})
                                 - $signed(`FMSD_HYST_DEGC);
  wire lt_cooled = $signed({local_temp[7], local_temp}) <= shut_rearm;

  // Pin pulled low by someone else while we release it
  wire ext_shut = ~hot_shutdown_pin_i & ~hot_shutdown_pin_oe;

  // Spin-up just finished
  wire spinup_end = spinup_prev & ~spinup_active;

  // Read strobes for the two status registers
  wire rd_s1 = reg_rd & (reg_addr == `FMSD_ADDR_STATUS1);
  wire rd_s2 = reg_rd & (reg_addr == `FMSD_ADDR_STATUS2);

  ////////////////////////////////////////////////////////////////////////////
  // Flag set terms, all sampled on the monitoring tick except the spin-up end term
  always @* begin
    flag_set = 9'h000;
    flag_set[F_REMOTE_LOW]  = mon_tick & rt_low;
    flag_set[F_REMOTE_HIGH] = mon_tick & rt_high;
    flag_set[F_FAN_SLOW]    = (mon_tick & ~spinup_active
                               & fan_slow)
                              | spinup_end;
    flag_set[F_OVERSPEED]   = mon_tick & fan_fast
                              & overspeed_armed;
    flag_set[F_SHUT_INPUT]  = mon_tick & ext_shut;
    flag_set[F_LOCAL_SHUT]  = mon_tick & lt_shut
                              & shut_armed;
    flag_set[F_PASSIVE]     = mon_tick & ct_psv;
    flag_set[F_LOCAL_CRIT]  = mon_tick & lt_crit;
    flag_set[F_REMOTE_CRIT] = mon_tick & rt_crit;
  end

  // A read clears exactly the bits it returns
  always @* begin
    flag_clr = 9'h000;
    flag_clr[F_REMOTE_LOW]  = rd_s1;
    flag_clr[F_REMOTE_HIGH] = rd_s1;
    flag_clr[F_FAN_SLOW]    = rd_s1;
    flag_clr[F_OVERSPEED]   = rd_s1;
    flag_clr[F_SHUT_INPUT]  = rd_s2;
    flag_clr[F_LOCAL_SHUT]  = rd_s2;
    flag_clr[F_PASSIVE]     = rd_s2;
    flag_clr[F_LOCAL_CRIT]  = rd_s2;
    flag_clr[F_REMOTE_CRIT] = rd_s2;
  end

  fmsd_sticky #(
    .W (9)
  ) u_flags (
    .clock (clock),
    .rst   (rst),
    .set   (flag_set),
    .clr   (flag_clr),
    .flag  (flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Spin-up edge tracking
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      spinup_prev <= 1'b0;
    end else begin
      spinup_prev <= spinup_active;
    end
  end

  // Consecutive slow count; spin-up ticks neither count nor reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      slow_run <= 3'h0;
    end else if (mon_tick & ~spinup_active) begin
      if (~fan_slow) begin
        slow_run <= 3'h0;
      end else if (slow_run != `FMSD_FAIL_COUNT) begin
        slow_run <= slow_run + 3'h1;
      end
    end
  end

  // Overspeed re-arms only once the fan is below the maximum again
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      overspeed_armed <= 1'b1;
    end else if (mon_tick & ~fan_fast) begin
      overspeed_armed <= 1'b1;
    end else if (rd_s1 & flags[F_OVERSPEED]
                 & ~flag_set[F_OVERSPEED]) begin
      overspeed_armed <= 1'b0;
    end
  end

  // Shutdown flag held off after a clear until 5C of cooling
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      shut_armed <= 1'b1;
    end else if (mon_tick & lt_cooled) begin
      shut_armed <= 1'b1;
    end else if (rd_s2 & flags[F_LOCAL_SHUT]
                 & ~flag_set[F_LOCAL_SHUT]) begin
      shut_armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty register; in other modes it is only the shadow copy
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      duty_setting <= `FMSD_RST_DUTY;
    end else if (reg_wr & (reg_addr == `FMSD_ADDR_DUTY)) begin
      duty_setting <= reg_wdata;
    end
  end

  // Calculated duty, then the clamps and the shutdown override
  always @* begin
    duty_calc    = mode_sw_duty ? duty_setting : loop_duty;
    duty_drive   = duty_calc;
    clamp_active = 1'b0;
    if (~tach_sampling_mode & mode_sw_speed
        & (duty_calc < `FMSD_DUTY_MIN_SPEED)) begin
      duty_drive   = `FMSD_DUTY_MIN_SPEED;
      clamp_active = 1'b1;
    end else if (~tach_sampling_mode & (mode_sw_duty | mode_auto)
                 & (duty_calc < `FMSD_DUTY_MIN_DUTY)) begin
      duty_drive   = `FMSD_DUTY_ZERO;
      clamp_active = 1'b1;
    end
    // Full speed wins over any clamp while another device holds the pin low
    if (ext_shut) begin
      duty_drive   = `FMSD_DUTY_FULL;
      clamp_active = 1'b0;
    end
  end

  fmsd_pwm u_pwm (
    .clock (clock),
    .rst   (rst),
    .step  (pwm_step),
    .duty  (duty_drive),
    .pwm   (pwm_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped offsets and absent bits read zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `FMSD_ADDR_STATUS1: begin
        next_rdata[`FMSD_S1_REMOTE_LOW]  = flags[F_REMOTE_LOW];
        next_rdata[`FMSD_S1_REMOTE_HIGH] = flags[F_REMOTE_HIGH];
        next_rdata[`FMSD_S1_FAN_SLOW]    = flags[F_FAN_SLOW];
        next_rdata[`FMSD_S1_OVERSPEED]   = flags[F_OVERSPEED];
      end
      `FMSD_ADDR_STATUS2: begin
        // Low three bits stay at zero
        next_rdata[`FMSD_S2_SHUT_INPUT]  = flags[F_SHUT_INPUT];
        next_rdata[`FMSD_S2_LOCAL_SHUT]  = flags[F_LOCAL_SHUT];
        next_rdata[`FMSD_S2_PASSIVE]     = flags[F_PASSIVE];
        next_rdata[`FMSD_S2_LOCAL_CRIT]  = flags[F_LOCAL_CRIT];
        next_rdata[`FMSD_S2_REMOTE_CRIT] = flags[F_REMOTE_CRIT];
      end
      `FMSD_ADDR_DUTY: begin
        next_rdata = clamp_active ? duty_calc : duty_drive;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data captured on the strobe, held until the next read
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins, all registered so nothing glitches onto a wire
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hot_shutdown_pin_o  <= 1'b0;
      hot_shutdown_pin_oe <= 1'b0;
      overtemp_output_n   <= 1'b1;
      fan_fault_n         <= 1'b1;
      alert_n             <= 1'b1;
    end else begin
      // Open drain: only ever drives low
      hot_shutdown_pin_o  <= 1'b0;
      hot_shutdown_pin_oe <= flags[F_LOCAL_SHUT];
      overtemp_output_n   <= ~(flags[F_LOCAL_CRIT]
                               | flags[F_REMOTE_CRIT]);
      // Fed by the slow count only, never by overspeed
      fan_fault_n <= ~(slow_run == `FMSD_FAIL_COUNT);
      alert_n <= ~((fan_range_alert_enable
                    & (flags[F_FAN_SLOW]
                       | flags[F_OVERSPEED]))
                   | (overheat_alert_enable
                      & flags[F_LOCAL_SHUT])
                   | (passive_alert_enable
                      & flags[F_PASSIVE])
                   | flags[F_LOCAL_CRIT]
                   | flags[F_REMOTE_CRIT]);
    end
  end

endmodule // fmsd_top

// *** tb/fmsd_top_sva.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Port-level checks on the status reads and the output pins
module fmsd_top_sva #(
  parameter MON_CYCLES = 20
) (
  input wire        clock,
  input wire        rst,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_rdata,
  input wire [7:0]  remote_temp,
  input wire [7:0]  remote_crit_limit,
  input wire [7:0]  local_temp,
  input wire [7:0]  local_shutdown_limit,
  input wire [7:0]  local_crit_limit,
  input wire [15:0] tach_count,
  input wire [15:0] tach_low_limit,
  input wire        hot_shutdown_pin_o,
  input wire        hot_shutdown_pin_oe,
  input wire        overtemp_output_n,
  input wire        fan_fault_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Four cycles of cause history, enough for tick, flag and pin latency
  reg [3:0] hist_shut;
  reg [3:0] hist_crit;
  reg [3:0] hist_slow;
  always @(posedge clock) begin
    hist_shut <= {hist_shut[2:0],
                  $signed(local_temp) > $signed(local_shutdown_limit)};
    hist_crit <= {hist_crit[2:0],
                  ($signed(local_temp) >= $signed(local_crit_limit)) ||
                  ($signed(remote_temp) >= $signed(remote_crit_limit))};
    hist_slow <= {hist_slow[2:0], tach_count >= tach_low_limit};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  sequence s_read(a);
    reg_rd && reg_addr == a;
  endsequence

  a_s2_reserved: assert property (
    s_read(8'h03) |=> reg_rdata[2:0] == 3'h0)
    else $error("status 2 low bits read nonzero");
  a_s1_upper: assert property (
    s_read(8'h02) |=> reg_rdata[7:4] == 4'h0)
    else $error("status 1 upper bits read nonzero");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr != 8'h02 && reg_addr != 8'h03 && reg_addr != 8'h22
    |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_rdata_stands: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  ////////////////////////////////////////////////////////////////////////////
  // Pins against their causes
  a_pin_drive_low: assert property (
    hot_shutdown_pin_oe |-> !hot_shutdown_pin_o)
    else $error("shutdown pin driven high");
  a_shut_cause: assert property (
    $rose(hot_shutdown_pin_oe) |-> |hist_shut)
    else $error("shutdown pin pulled without hot local");
  a_ovr_cause: assert property (
    $fell(overtemp_output_n) |-> |hist_crit)
    else $error("overtemp pin low without critical temp");
  a_fault_cause: assert property (
    $fell(fan_fault_n) |-> |hist_slow)
    else $error("fan fault without slow fan");
  a_fault_release: assert property (
    $rose(fan_fault_n) |-> |(~hist_slow))
    else $error("fan fault released while slow");
endmodule // fmsd_top_sva

bind fmsd_top fmsd_top_sva #(.MON_CYCLES(MON_CYCLES)) fmsd_top_sva_u (.*);

// *** tb/fmsd_far_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Board side of the open-drain shutdown line, pulled up when nobody pulls
module fmsd_far_model (
  input  wire hot_shutdown_pin_o,
  input  wire hot_shutdown_pin_oe,
  input  wire ext_pull_low,
  output wire pin_level
);
  // Either party may sink the line; a driven 1 never wins over a sink
  assign pin_level = ~((hot_shutdown_pin_oe & ~hot_shutdown_pin_o) |
                       ext_pull_low);
endmodule // fmsd_far_model

// *** tb/fmsd_top_bench.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module fmsd_top_bench;
  localparam MON = 20;
  localparam PER = 255 * 31;
  logic        clock, rst, reg_rd, reg_wr, spinup_active, ext_pull_low;
  logic        tach_sampling_mode, mode_sw_speed, mode_sw_duty, mode_auto;
  logic        overheat_alert_enable, passive_alert_enable;
  logic        fan_range_alert_enable, hot_shutdown_pin_i;
  logic        hot_shutdown_pin_o, hot_shutdown_pin_oe;
  logic        alert_n, overtemp_output_n, fan_fault_n, pwm_out;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, rnd, e1, e2;
  logic [7:0]  remote_temp, remote_low_limit, remote_high_limit;
  logic [7:0]  remote_crit_limit, local_temp, local_shutdown_limit;
  logic [7:0]  local_crit_limit, control_temp, passive_temp, loop_duty;
  logic [15:0] tach_count, tach_low_limit, tach_high_limit;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  fmsd_top #(.MON_CYCLES(MON)) dut_u (.*);
  fmsd_far_model far_u (
    .hot_shutdown_pin_o  (hot_shutdown_pin_o),
    .hot_shutdown_pin_oe (hot_shutdown_pin_oe),
    .ext_pull_low        (ext_pull_low),
    .pin_level           (hot_shutdown_pin_i)
  );

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard; a clean run needs about 75000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One-cycle strobes, data taken after the answering edge
  task rd(input logic [7:0] a);
    @(negedge clock);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clock);
    reg_rd = 0;
    rv = reg_rdata;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clock);
    reg_wr = 0;
  endtask

  task ticks(input int n);
    repeat (n * MON) @(negedge clock);
  endtask

  // In-range inputs, then reads that flush any stale sticky flags
  task neutral;
    @(negedge clock);
    {remote_temp, local_temp, control_temp} = {8'h28, 8'h28, 8'h32};
    {tach_count, ext_pull_low, spinup_active} = {16'h03E8, 2'b00};
    ticks(2);
    rd(8'h02);
    rd(8'h03);
  endtask

  function automatic logic [7:0] exp_s2(input logic first);
    exp_s2 = {ext_pull_low,
              first && $signed(local_temp) > $signed(local_shutdown_limit),
              $signed(control_temp) <= $signed(passive_temp),
              $signed(local_temp) >= $signed(local_crit_limit),
              $signed(remote_temp) >= $signed(remote_crit_limit), 3'h0};
  endfunction

  // Mode {speed,duty,auto,tach}, optional write, read back, count highs
  task duty_case(input logic [3:0] md, input logic wen, input logic [7:0] wd,
                 input logic [7:0] ld, input logic [7:0] er,
                 input logic [15:0] eh);
    logic [15:0] hi;
    @(negedge clock);
    {mode_sw_speed, mode_sw_duty, mode_auto, tach_sampling_mode} = md;
    loop_duty = ld;
    if (wen) wr(8'h22, wd);
    rd(8'h22);
    check(rv, er);
    // Old duty lingers until the next PWM step, so skip one step first
    repeat (31) @(negedge clock);
    hi = 0;
    repeat (PER) begin
      @(negedge clock);
      hi = hi + 16'(pwm_out);
    end
    check(hi, eh);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_rd, reg_wr, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {spinup_active, ext_pull_low, mode_sw_speed, mode_auto} = 4'h0;
    {mode_sw_duty, tach_sampling_mode, loop_duty} = {2'b10, 8'h00};
    {overheat_alert_enable, passive_alert_enable} = 2'b11;
    fan_range_alert_enable = 1;
    {remote_temp, local_temp, control_temp} = {8'h28, 8'h28, 8'h32};
    {remote_low_limit, remote_high_limit} = {8'h00, 8'h50};
    {remote_crit_limit, local_shutdown_limit} = {8'h64, 8'h5A};
    {local_crit_limit, passive_temp} = {8'h64, 8'h14};
    {tach_count, tach_low_limit} = {16'h03E8, 16'h07D0};
    tach_high_limit = 16'h01F4;
    void'($urandom(66));
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 0;
    rd(8'h22);
    check(rv, 8'h55);
    wr(8'h03, 8'hFF);
    rd(8'h03);
    check(rv, 8'h00);
    rd(8'hFF);
    check(rv, 8'h00);
    // Random remote and tach values, with limit boundaries first
    for (int i = 0; i < 10; i++) begin
      neutral();
      remote_low_limit = 8'($urandom % 40);
      remote_high_limit = 8'(41 + $urandom % 40);
      tach_low_limit = 16'(1001 + $urandom % 2000);
      remote_temp = 8'($urandom % 90);
      tach_count = 16'(501 + $urandom % 3000);
      if (i == 0) remote_temp = remote_low_limit;
      if (i == 1) remote_temp = remote_high_limit;
      if (i == 2) tach_count = tach_low_limit;
      e1 = {4'h0, remote_temp <= remote_low_limit,
            remote_temp >= remote_high_limit, tach_count >= tach_low_limit,
            1'b0};
      ticks(2);
      rd(8'h02);
      check(rv, e1);
      ticks(2);
      rd(8'h02);
      check(rv, e1);
    end
    // Overspeed at the limit: alert, no fan fault, re-arm after slowing
    neutral();
    tach_count = tach_high_limit;
    ticks(2);
    check(alert_n, 1'b0);
    rd(8'h02);
    check(rv, 8'h01);
    ticks(7);
    check(fan_fault_n, 1'b1);
    rd(8'h02);
    check(rv, 8'h00);
    tach_count = 16'h03E8;
    ticks(2);
    tach_count = tach_high_limit;
    ticks(2);
    rd(8'h02);
    check(rv, 8'h01);
    // Stalled fan: not yet failed at four ticks, failed by the fifth
    neutral();
    tach_count = 16'hFFFF;
    repeat (4 * MON - 3) @(negedge clock);
    check(fan_fault_n, 1'b1);
    ticks(2);
    check(fan_fault_n, 1'b0);
    tach_count = 16'h03E8;
    ticks(2);
    check(fan_fault_n, 1'b1);
    // Spin-up hides slowness, its end forces the slow flag once
    neutral();
    {spinup_active, tach_count} = {1'b1, 16'hFFFF};
    ticks(2);
    rd(8'h02);
    ticks(2);
    rd(8'h02);
    check(rv & 8'h02, 8'h00);
    {spinup_active, tach_count} = {1'b0, 16'h03E8};
    ticks(2);
    rd(8'h02);
    check(rv, 8'h02);
    ticks(2);
    rd(8'h02);
    check(rv, 8'h00);
    // Status 2 causes, each with random alert enables
    for (int i = 0; i < 5; i++) begin
      neutral();
      {overheat_alert_enable, passive_alert_enable} = 2'($urandom);
      case (i)
        0: ext_pull_low = 1;
        1: local_temp = local_shutdown_limit + 8'h01;
        2: control_temp = passive_temp;
        3: local_temp = local_crit_limit;
        default: remote_temp = remote_crit_limit;
      endcase
      e1 = exp_s2(1'b1);
      e2 = exp_s2(1'b0);
      ticks(2);
      check(overtemp_output_n, !(e1[4] | e1[3]));
      check(hot_shutdown_pin_oe, e1[6]);
      if (i != 0) check(alert_n, !(e1[4] | e1[3] | (e1[6] & overheat_alert_enable) | (e1[5] & passive_alert_enable)));
      if (i == 0) begin
        check(pwm_out, 1'b1);
        rd(8'h22);
        check(rv, 8'hFF);
      end
      rd(8'h03);
      check(rv, e1);
      ticks(2);
      rd(8'h03);
      check(rv, e2);
    end
    neutral();
    // Duty codes, clamps, shadow and modes
    rnd = 8'($urandom);
    duty_case(4'b0100, 1, 8'h00, 8'h00, 8'h00, 16'h0000);
    duty_case(4'b0101, 1, 8'h01, 8'h00, 8'h01, 16'(31));
    duty_case(4'b0100, 1, 8'h11, 8'h00, 8'h11, 16'h0000);
    duty_case(4'b0100, 1, 8'hFF, 8'h00, 8'hFF, 16'(PER));
    duty_case(4'b1000, 1, 8'h90, 8'h20, 8'h20, 16'(31 * 8'h4D));
    duty_case(4'b1001, 0, 8'h00, 8'h20, 8'h20, 16'(31 * 8'h20));
    duty_case(4'b0010, 0, 8'h00, 8'h11, 8'h11, 16'h0000);
    duty_case(4'b0100, 0, 8'h00, 8'h00, 8'h90, 16'(31 * 8'h90));
    duty_case(4'b0101, 1, rnd, 8'h00, rnd, 16'(31 * rnd));
    end_sim();
  end
endmodule // fmsd_top_bench
